/* File: csc_cfg.svh */
// Constants of the charge sequence controller: offsets, resets, timings.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
// Clock rate
`define CSC_CLK_MHZ 10
// Register byte offsets
`define CSC_OFS_CTRL 8'h00
`define CSC_OFS_VREG 8'h04
`define CSC_OFS_ICHG 8'h08
`define CSC_OFS_DUTY 8'h0C
`define CSC_OFS_STAT 8'h10
// Control bit positions
`define CSC_B_DIS 0
`define CSC_B_PRST 1
`define CSC_B_BST 2
`define CSC_B_HIZ 3
`define CSC_B_TERM 4
`define CSC_B_STEN 5
`define CSC_B_KICK 6
// Reset values, regulation code ceiling and short current code
`define CSC_VREG_DEF 6'h02
`define CSC_VREG_MAX 6'h2F
`define CSC_ICHG_DEF 4'h0
`define CSC_IIN_DEF 4'h0
`define CSC_DUTY_DEF 8'h80
`define CSC_SHORT_CODE 4'h0
// Timing: one millisecond tick, times in ms except the tick and pulse (us) and ramp (cycles)
`define CSC_TICK_US 1000
`define CSC_DEGL_MS 32
`define CSC_DET_MS 262
`define CSC_SYNC_MS 40
`define CSC_T15_MS 900000
`define CSC_WDG_MS 32000
`define CSC_PULSE_US 128
`define CSC_RAMP_CYC 1000
// Modulator: period in cycles, maximum on time per mille
`define CSC_PWM_PER 200
`define CSC_MAXON_PM 995
`endif

/* File: csc_pkg.sv */
// Types of the charge sequence controller.
// Assumes csc_cfg.svh holds every number.
package csc_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    S_HIZ = 3'b000, S_PRE = 3'b001, S_FAST = 3'b010, S_DET = 3'b011,
    S_SYNC = 3'b100, S_DONE = 3'b101, S_CFG = 3'b110, S_BOOST = 3'b111
  } csc_state_t;
  // Operating mode reported to the power stage
  typedef enum logic [1:0] {
    M_HIZ = 2'b00, M_CHG = 2'b01, M_CFG = 2'b10, M_BST = 2'b11
  } csc_mode_t;
  // Comparator and event inputs from the analog side
  typedef struct packed {
    logic bat_short;      // Battery below short threshold
    logic bat_below_rch;  // Battery below recharge threshold
    logic bat_below_weak; // Battery below weak-battery threshold
    logic end_current_level_det;      // End current level reached
    logic hs_ilim;        // High-side switch at peak limit
    logic ls_above_thr;   // Low-side current above sync threshold
    logic vbus_below_bat; // Bus below battery sense node
    logic vbus_uvlo;      // Bus below undervoltage
    logic tj_fold;        // Die above thermal fold threshold
    logic tj_fold_hi;     // Die ten degrees above fold
    logic tj_shut;        // Die above thermal cutoff
    logic tj_cool;        // Die ten degrees below cutoff
    logic bus_por;        // Bus power-on reset pulse
    logic chg_fault;      // Any analog charge-mode fault
    logic bst_fault;      // Any analog boost-mode fault
  } csc_sense_t;
  // Drives to the power stage
  typedef struct packed {
    logic hs_on;          // High-side switch gate
    logic ls_on;          // Low-side switch gate
    logic blk_on;         // Input blocking FET gate
    logic det_sink;       // Detection sink current enable
    logic [3:0] cur;      // Charge current code
    logic [5:0] vreg;     // Regulation voltage code
    csc_mode_t mode;      // Operating mode
  } csc_drive_t;
  // Whole state of the controller
  typedef struct packed {
    csc_state_t st;
    logic [13:0] pre;     // Millisecond prescaler
    logic [8:0] tmr;      // Deglitch, detection, sync timer
    logic [19:0] t15;     // Fifteen-minute timer
    logic [14:0] wdg;     // Watchdog timer
    logic [10:0] pls;     // Fault pulse countdown
    logic [9:0] rmp;      // Current slew divider
    logic [7:0] pcnt;     // Modulator period count
    logic ilim_hit;       // Peak limit seen this period
    logic host;           // Host mode
    logic flt_d;          // Fault seen last cycle
    logic tflt;           // Timer fault, sticky
    logic thot;           // Thermal shutdown latch
    logic dis_d;          // Charge-disable last value
    logic [6:0] ctrl;     // Control bits
    logic [5:0] vreg;
    logic [3:0] ichg;
    logic [3:0] iin;
    logic [3:0] cur;
    logic [7:0] duty;
    logic [31:0] rdata;
  } csc_st_t;
endpackage

/* File: csc_ctrl.sv */
// Charge sequence controller: sequencing, timers, indicator, APB regs.
// Assumes synchronous comparator inputs and a zero-wait APB master.
//
// Operation
// - Fixed-period modulator, on-time up to 99.5%
// - Blocking FET off when bus below battery
// - Peak high-side current ends on-time
// - Low-side synchronous only above current threshold
// - Short current while battery below short
// - Slew current to fast or input-limited level
// - Host regulation voltage, fixed in timer mode
// - Deglitch plus end current starts detection
// - Battery still high after detection means done
// - Show done only after sync delay
// - Termination bit zero blocks end sequence
// - Start new cycle on listed triggers
// - Fold current back with die temperature
// - Cutoff suspends charging and freezes the millisecond timers
// - Indicator low while charging and enabled
// - Charge faults give one indicator pulse
// - Boost faults give the same pulse
// - Charge-disable bit one stops charging
// - Parameter reset restores defaults, self-clears
// - Charge, configure or high impedance by faults
// - Boost select and high impedance select
// - Timer mode first, host write starts watchdog
// - Fifteen-minute expiry stops charge with fault
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "csc_cfg.svh"

module csc_ctrl #(
  parameter int TICK_CYC = `CSC_TICK_US * `CSC_CLK_MHZ, // Cycles a ms
  parameter int T15_MS = `CSC_T15_MS,   // Safety timer length
  parameter int WDG_MS = `CSC_WDG_MS,   // Watchdog length
  parameter int PWM_PER = `CSC_PWM_PER  // Modulator period
) (
  input wire logic mclk,                // Core clock
  input wire logic arst_n,              // Async reset
  input wire logic ce,                  // Clock enable
  input wire logic psel,                // APB select
  input wire logic penable,             // APB enable
  input wire logic pwrite,              // APB direction
  input wire logic [7:0] paddr,         // APB byte address
  input wire logic [31:0] pwdata,       // APB write data
  output logic [31:0] prdata,           // APB read data
  output logic pready,                  // APB ready
  output logic pslverr,                 // APB error
  input wire csc_pkg::csc_sense_t sns,  // Analog comparators
  output csc_pkg::csc_drive_t drv,      // Power stage drives
  input wire logic stat_i,              // Indicator pin level
  output logic stat_o,                  // Indicator pin drive
  output logic stat_oe                  // Indicator pin enable
);

  localparam int PULSE_CYC = `CSC_PULSE_US * `CSC_CLK_MHZ;
  localparam int MAXON = PWM_PER * `CSC_MAXON_PM / 1000;

  csc_pkg::csc_st_t s_r;   // Registered state
  csc_pkg::csc_st_t s_nxt; // Next state
  logic tick;              // One-ms timer tick
  logic wr;                // APB write strobe
  logic hit;               // Mapped address
  logic chg_st;            // Charging in progress
  logic pwm_en;            // Modulator may switch
  logic flt_c;             // Charge-mode fault level
  logic flt_now;           // Fault of current mode
  logic restart;           // New charge cycle trigger
  logic [3:0] tgt;         // Current target
  logic unused_pin;        // Pin readback not needed

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  // Decoded mapped offset
  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == `CSC_OFS_CTRL) || (a == `CSC_OFS_VREG) ||
             (a == `CSC_OFS_ICHG) || (a == `CSC_OFS_DUTY) ||
             (a == `CSC_OFS_STAT);
  endfunction

  // Smaller of two current codes
  function automatic logic [3:0] min4(input logic [3:0] a,
                                      input logic [3:0] b);
    min4 = (a < b) ? a : b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Decodes
  assign unused_pin = stat_i;
  assign tick = (s_r.pre == 14'(TICK_CYC - 1)) && !s_r.thot;
  assign wr = psel && penable && pwrite;
  assign hit = is_reg(paddr);
  assign chg_st = (s_r.st == csc_pkg::S_PRE) ||
                  (s_r.st == csc_pkg::S_FAST) ||
                  (s_r.st == csc_pkg::S_DET) ||
                  (s_r.st == csc_pkg::S_SYNC);
  // Modulator stops in detection and in thermal shutdown
  assign pwm_en = !s_r.thot && ((s_r.st == csc_pkg::S_PRE) ||
                  (s_r.st == csc_pkg::S_FAST) ||
                  (s_r.st == csc_pkg::S_BOOST));
  assign flt_c = sns.chg_fault || s_r.tflt || sns.vbus_uvlo;
  assign flt_now = s_r.thot ||
                   ((s_r.st == csc_pkg::S_BOOST) ? sns.bst_fault : flt_c);
  // Restart triggers of a new cycle
  assign restart = (sns.bus_por && sns.bat_below_weak) ||
                   (s_r.ctrl[`CSC_B_DIS] != s_r.dis_d) ||
                   s_r.ctrl[`CSC_B_PRST];
  // Fold target: half current in fold, zero ten degrees above
  assign tgt = sns.tj_fold_hi ? 4'h0 :
               sns.tj_fold ? (min4(s_r.ichg, s_r.iin) >> 1) :
               min4(s_r.ichg, s_r.iin);

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.pre = tick || (s_r.pre == 14'(TICK_CYC - 1)) ? 14'h0000 :
                (s_r.thot ? s_r.pre : s_r.pre + 14'h0001);
    s_nxt.dis_d = s_r.ctrl[`CSC_B_DIS];
    s_nxt.flt_d = flt_now;
    s_nxt.ctrl[`CSC_B_PRST] = 1'b0;
    s_nxt.ctrl[`CSC_B_KICK] = 1'b0;
    // Thermal latch with hysteresis
    if (sns.tj_shut) begin
      s_nxt.thot = 1'b1;
    end else if (sns.tj_cool) begin
      s_nxt.thot = 1'b0;
    end
    // Modulator period and peak-limit latch
    if (s_r.pcnt == 8'(PWM_PER - 1)) begin
      s_nxt.pcnt = 8'h00;
      s_nxt.ilim_hit = 1'b0;
    end else begin
      s_nxt.pcnt = s_r.pcnt + 8'h01;
      if (sns.hs_ilim) begin
        s_nxt.ilim_hit = 1'b1;
      end
    end
    // Fault pulse on each fault entry only
    if (flt_now && !s_r.flt_d) begin
      s_nxt.pls = 11'(PULSE_CYC);
    end else if (s_r.pls != 11'h000) begin
      s_nxt.pls = s_r.pls - 11'h001;
    end
    // Current slew toward target
    if (s_r.st == csc_pkg::S_PRE) begin
      s_nxt.cur = `CSC_SHORT_CODE;
    end else if (s_r.rmp == 10'(`CSC_RAMP_CYC - 1)) begin
      s_nxt.rmp = 10'h000;
      if (s_r.cur < tgt) begin
        s_nxt.cur = s_r.cur + 4'h1;
      end else if (s_r.cur > tgt) begin
        s_nxt.cur = s_r.cur - 4'h1;
      end
    end else begin
      s_nxt.rmp = s_r.rmp + 10'h001;
    end
    // Safety timer in timer mode while charging
    if (!s_r.host && chg_st && tick) begin
      if (s_r.t15 == 20'(T15_MS - 1)) begin
        s_nxt.tflt = 1'b1;
        s_nxt.t15 = 20'h00000;
      end else begin
        s_nxt.t15 = s_r.t15 + 20'h00001;
      end
    end
    // Watchdog in host mode; expiry drops back to timer mode
    if (s_r.host && tick) begin
      if (s_r.wdg == 15'(WDG_MS - 1)) begin
        s_nxt.host = 1'b0;
        s_nxt.wdg = 15'h0000;
        s_nxt.vreg = `CSC_VREG_DEF;
        s_nxt.ichg = `CSC_ICHG_DEF;
        s_nxt.iin = `CSC_IIN_DEF;
      end else begin
        s_nxt.wdg = s_r.wdg + 15'h0001;
      end
    end
    // Sequencer, frozen in thermal shutdown
    if (!s_r.thot) begin
      case (s_r.st)
        csc_pkg::S_PRE: begin
          if (!sns.bat_short) begin
            s_nxt.st = csc_pkg::S_FAST;
          end
        end
        csc_pkg::S_FAST: begin
          if (!(s_r.host && s_r.ctrl[`CSC_B_TERM]) ||
              sns.bat_below_rch) begin
            s_nxt.tmr = 9'h000;
          end else if (s_r.tmr < 9'(`CSC_DEGL_MS)) begin
            s_nxt.tmr = s_r.tmr + {8'h00, tick};
          end else if (sns.end_current_level_det) begin
            s_nxt.st = csc_pkg::S_DET;
            s_nxt.tmr = 9'h000;
          end
        end
        csc_pkg::S_DET: begin
          if (s_r.tmr == 9'(`CSC_DET_MS)) begin
            s_nxt.tmr = 9'h000;
            // Battery absent: defaults and resume
            if (sns.bat_below_rch) begin
              s_nxt.st = csc_pkg::S_PRE;
              s_nxt.vreg = `CSC_VREG_DEF;
              s_nxt.ichg = `CSC_ICHG_DEF;
              s_nxt.iin = `CSC_IIN_DEF;
            end else begin
              s_nxt.st = csc_pkg::S_SYNC;
            end
          end else begin
            s_nxt.tmr = s_r.tmr + {8'h00, tick};
          end
        end
        csc_pkg::S_SYNC: begin
          if (s_r.tmr == 9'(`CSC_SYNC_MS)) begin
            s_nxt.st = csc_pkg::S_DONE;
            s_nxt.tmr = 9'h000;
          end else begin
            s_nxt.tmr = s_r.tmr + {8'h00, tick};
          end
        end
        csc_pkg::S_DONE: begin
          if (sns.bat_below_rch) begin
            s_nxt.st = csc_pkg::S_PRE;
          end
        end
        default: begin
          s_nxt.st = csc_pkg::S_PRE;
          s_nxt.tmr = 9'h000;
        end
      endcase
      // Mode selection overrides the charge sequence
      if (s_r.ctrl[`CSC_B_HIZ] || s_r.ctrl[`CSC_B_DIS]) begin
        s_nxt.st = csc_pkg::S_HIZ;
      end else if (s_r.ctrl[`CSC_B_BST]) begin
        s_nxt.st = sns.bst_fault ? csc_pkg::S_CFG :
                   csc_pkg::S_BOOST;
      end else if (flt_c) begin
        s_nxt.st = sns.vbus_uvlo ? csc_pkg::S_HIZ :
                   csc_pkg::S_CFG;
      end else if (restart || !(chg_st || s_r.st == csc_pkg::S_DONE)) begin
        s_nxt.st = csc_pkg::S_PRE;
        s_nxt.tmr = 9'h000;
      end
    end
    // Bus power-on clears the timer fault; a new expiry still wins
    if (sns.bus_por && !(tick && s_nxt.tflt && !s_r.tflt)) begin
      s_nxt.tflt = 1'b0;
    end
    // Read data latched in the setup phase
    if (psel && !penable) begin
      case (paddr)
        `CSC_OFS_CTRL: s_nxt.rdata = {25'h0000000, s_r.ctrl};
        `CSC_OFS_VREG: s_nxt.rdata = {26'h0000000, s_r.vreg};
        `CSC_OFS_ICHG: s_nxt.rdata = {24'h000000, s_r.iin, s_r.ichg};
        `CSC_OFS_DUTY: s_nxt.rdata = {24'h000000, s_r.duty};
        `CSC_OFS_STAT: s_nxt.rdata = {21'h000000, s_r.cur, s_r.st,
                                      s_r.thot, s_r.tflt, s_r.host,
                                      flt_now};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
    // Register writes; any mapped write puts the block in host mode
    if (wr && hit) begin
      s_nxt.host = 1'b1;
      s_nxt.wdg = 15'h0000;
      s_nxt.t15 = 20'h00000;
      case (paddr)
        `CSC_OFS_CTRL: begin
          s_nxt.ctrl = pwdata[6:0];
          if (pwdata[`CSC_B_PRST]) begin
            s_nxt.vreg = `CSC_VREG_DEF;
            s_nxt.ichg = `CSC_ICHG_DEF;
            s_nxt.iin = `CSC_IIN_DEF;
            s_nxt.duty = `CSC_DUTY_DEF;
            s_nxt.ctrl[`CSC_B_TERM] = 1'b1;
            s_nxt.ctrl[`CSC_B_STEN] = 1'b1;
          end
        end
        `CSC_OFS_VREG: begin
          s_nxt.vreg = (pwdata[5:0] > `CSC_VREG_MAX) ? `CSC_VREG_MAX :
                       pwdata[5:0];
        end
        `CSC_OFS_ICHG: begin
          s_nxt.ichg = pwdata[3:0];
          s_nxt.iin = pwdata[7:4];
        end
        `CSC_OFS_DUTY: s_nxt.duty = pwdata[7:0];
        default: s_nxt.duty = s_r.duty;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register, frozen while ce is low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.st <= csc_pkg::S_HIZ;
      s_r.ctrl <= 7'h30; // Termination and indicator enabled
      s_r.vreg <= `CSC_VREG_DEF;
      s_r.ichg <= `CSC_ICHG_DEF;
      s_r.iin <= `CSC_IIN_DEF;
      s_r.duty <= `CSC_DUTY_DEF;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = s_r.rdata;
  assign drv.hs_on = pwm_en && !s_r.ilim_hit && !sns.hs_ilim &&
                     (s_r.pcnt < s_r.duty) &&
                     (s_r.pcnt < 8'(MAXON));
  assign drv.ls_on = pwm_en && !drv.hs_on && sns.ls_above_thr;
  assign drv.blk_on = !sns.vbus_below_bat &&
                      (s_r.st != csc_pkg::S_HIZ);
  assign drv.det_sink = (s_r.st == csc_pkg::S_DET);
  assign drv.cur = s_r.cur;
  assign drv.vreg = s_r.host ? s_r.vreg : `CSC_VREG_DEF;
  assign drv.mode = (s_r.st == csc_pkg::S_HIZ) ? csc_pkg::M_HIZ :
                    (s_r.st == csc_pkg::S_CFG) ? csc_pkg::M_CFG :
                    (s_r.st == csc_pkg::S_BOOST) ? csc_pkg::M_BST :
                    csc_pkg::M_CHG;
  assign stat_o = 1'b0;
  // Pulse takes priority; otherwise low while charging
  assign stat_oe = (s_r.pls != 11'h000) ||
                   (chg_st && s_r.ctrl[`CSC_B_STEN]);

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_blk;
    sns.vbus_below_bat |-> !drv.blk_on;
  endproperty
  a_blk: assert property (p_blk) else $error("blocking FET on");

  property p_ilim;
    ce && sns.hs_ilim && s_r.pcnt != 8'(PWM_PER - 1) |=> !drv.hs_on;
  endproperty
  a_ilim: assert property (p_ilim) else $error("on after limit");

  property p_ls;
    !sns.ls_above_thr |-> !drv.ls_on;
  endproperty
  a_ls: assert property (p_ls) else $error("low side on");

  property p_short;
    ce && s_r.st == csc_pkg::S_PRE |=> drv.cur == `CSC_SHORT_CODE;
  endproperty
  a_short: assert property (p_short) else $error("not short");

  property p_vreg;
    !s_r.host |-> drv.vreg == `CSC_VREG_DEF;
  endproperty
  a_vreg: assert property (p_vreg) else $error("vreg not fixed");

  property p_noterm;
    ce && !s_r.ctrl[`CSC_B_TERM] && s_r.st == csc_pkg::S_FAST
      |=> s_r.st != csc_pkg::S_DET;
  endproperty
  a_noterm: assert property (p_noterm) else $error("term off");

  property p_pulse;
    ce && flt_now && !s_r.flt_d |=> stat_oe [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("no pulse");

  property p_hot;
    s_r.thot |-> !drv.hs_on ##1 $stable(s_r.t15);
  endproperty
  a_hot: assert property (p_hot) else $error("not frozen");

  property p_prst;
    s_r.ctrl[`CSC_B_PRST] && ce |=> !s_r.ctrl[`CSC_B_PRST];
  endproperty
  a_prst: assert property (p_prst) else $error("reset stuck");

  property p_dis;
    ce && s_r.ctrl[`CSC_B_DIS] && !s_r.thot
      |=> s_r.st == csc_pkg::S_HIZ;
  endproperty
  a_dis: assert property (p_dis) else $error("charge on");

  c_done: cover property (s_r.st == csc_pkg::S_DONE);
  c_det: cover property (s_r.st == csc_pkg::S_DET);
  c_bst: cover property (s_r.st == csc_pkg::S_BOOST);
  c_pls: cover property (s_r.pls == 11'h001);

endmodule

/* File: csc_batt_model.sv */
// Battery pack and comparator front end facing the charge controller.
// Assumes the bench commands the comparator levels through cmd.
`timescale 1ns/10ps
module csc_batt_model (
  input wire logic mclk, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire csc_pkg::csc_sense_t cmd, // Levels set by the bench
  input wire logic absent, // Pack removed
  input wire csc_pkg::csc_drive_t drv, // Power stage drives
  output csc_pkg::csc_sense_t sns // Comparator outputs
);
  logic sag_r; // Node collapsed under the sink
  ////////////////////////////////////////////////////////////////////////
  // No pack holds the node up, so the sink drags it down and it stays
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sag_r <= 1'b0;
    end else begin
      sag_r <= absent & (sag_r | drv.det_sink);
    end
  end
  // Node follows the bench unless it has sagged
  always_comb begin
    sns = cmd;
    sns.bat_below_rch = cmd.bat_below_rch | sag_r;
  end
endmodule

/* File: charge_sequence_controller_tb_top.sv */
// Self-checking bench for the charge sequence controller over APB.
// Assumes shortened tick and timer parameters and a pulled-up pin.
`timescale 1ns/10ps
`include "csc_cfg.svh"
module charge_sequence_controller_tb_top;
  localparam logic [7:0] A_CTL = `CSC_OFS_CTRL; // Control word
  localparam logic [7:0] A_VRG = `CSC_OFS_VREG; // Regulation code
  localparam logic [7:0] A_STA = `CSC_OFS_STAT; // Status word
  logic mclk = 1'b0; // Core clock
  logic arst_n = 1'b0; // Async reset
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB enable
  logic pwrite = 1'b0; // APB direction
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0; // APB write data
  logic [31:0] prdata, rd; // Read data, last taken
  logic pready, pslverr, serr, stat_o, stat_oe; // Slave answers
  logic absent = 1'b0; // Pack removed
  csc_pkg::csc_sense_t cmd = '0; // Commanded comparator levels
  csc_pkg::csc_sense_t sns; // Comparators seen by the design
  csc_pkg::csc_drive_t drv; // Power stage drives
  logic [6:0] ctl = 7'h30; // Control image kept by the bench
  int fail_count = 0, samples_checked = 0; // Tallies
  int hs_n = 0, ls_n = 0, so_n = 0, h0 = 0, l0 = 0; // On-cycle counts
  wire stat_pin = stat_oe ? stat_o : 1'b1; // Pull-up on the pin
  ////////////////////////////////////////////////////////////////////////
  always #50 mclk = ~mclk;
  // Running tallies, read as differences to avoid clearing races
  always @(posedge mclk) begin
    hs_n <= hs_n + int'(drv.hs_on);
    ls_n <= ls_n + int'(drv.ls_on);
    so_n <= so_n + int'(stat_oe);
  end
  csc_ctrl #(.TICK_CYC(10), .T15_MS(200), .WDG_MS(100), .PWM_PER(200))
  i_dut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sns(sns),
    .drv(drv), .stat_i(stat_pin), .stat_o(stat_o), .stat_oe(stat_oe));
  csc_batt_model i_batt (.mclk(mclk), .arst_n(arst_n), .cmd(cmd),
    .absent(absent), .drv(drv), .sns(sns));
  ////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compare one value, report at once
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // No wait limit here; only the hang guard ends a stuck transfer
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control write, keeping the image; mode settles one edge later
  task setc(input logic [6:0] v);
    ctl = v;
    apb(1'b1, A_CTL, 32'(v));
    repeat (2) @(posedge mclk);
  endtask
  // Compare the sequencer state field
  task st(input csc_pkg::csc_state_t e);
    apb(1'b0, A_STA, 32'h0);
    chk(32'(rd[6:4]), 32'(e));
  endtask
  // Wait while kicking the watchdog so host mode holds
  task run(input int n);
    repeat (n / 200) begin
      repeat (200) @(posedge mclk);
      apb(1'b1, A_CTL, 32'(ctl | 7'h40));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Hang guard, about twice the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    print_verdict;
  end
  // Main sequence
  initial begin
    cmd.bat_short = 1'b1;
    cmd.bat_below_rch = 1'b1;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(drv.vreg), 32'(`CSC_VREG_DEF));
    chk(32'(drv.cur), 32'(`CSC_SHORT_CODE));
    chk(32'({stat_oe, stat_pin}), 32'h2);
    chk(32'(drv.mode), 32'(csc_pkg::M_CHG));
    apb(1'b0, A_CTL, 32'h0);
    chk(rd, 32'h30);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], serr}, 32'h1);
    apb(1'b1, A_VRG, 32'h3F);
    apb(1'b0, A_VRG, 32'h0);
    chk(rd, 32'h2F);
    chk(32'(drv.vreg), 32'h2F);
    apb(1'b1, `CSC_OFS_ICHG, 32'hF3);
    cmd.bat_short <= 1'b0;
    st(csc_pkg::S_FAST);
    chk(32'(drv.cur < 4'h3), 32'h1);
    run(4000);
    chk(32'(drv.cur), 32'h3);
    cmd.tj_fold <= 1'b1;
    run(2200);
    chk(32'(drv.cur), 32'h1);
    cmd.tj_fold <= 1'b0;
    chk(32'(ls_n), 32'h0);
    cmd.ls_above_thr <= 1'b1;
    apb(1'b1, `CSC_OFS_DUTY, 32'hFF);
    // One edge so the first counted cycle already sees the new duty
    @(posedge mclk);
    h0 = hs_n;
    l0 = ls_n;
    repeat (400) @(posedge mclk);
    chk(32'(hs_n - h0), 32'h18E);
    chk(32'(ls_n - l0), 32'h2);
    cmd.ls_above_thr <= 1'b0;
    cmd.hs_ilim <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(drv.hs_on), 32'h0);
    cmd.hs_ilim <= 1'b0;
    cmd.bat_below_rch <= 1'b0;
    cmd.end_current_level_det <= 1'b1;
    run(400);
    st(csc_pkg::S_DET);
    chk(32'({drv.det_sink, drv.hs_on}), 32'h2);
    run(2600);
    st(csc_pkg::S_SYNC);
    chk(32'(stat_oe), 32'h1);
    run(400);
    st(csc_pkg::S_DONE);
    chk(32'(stat_oe), 32'h0);
    cmd.bat_below_rch <= 1'b1;
    cmd.end_current_level_det <= 1'b0;
    st(csc_pkg::S_PRE);
    setc(7'h20);
    cmd.bat_below_rch <= 1'b0;
    cmd.end_current_level_det <= 1'b1;
    run(4000);
    st(csc_pkg::S_FAST);
    absent <= 1'b1;
    setc(7'h30);
    run(400);
    st(csc_pkg::S_DET);
    run(2600);
    apb(1'b0, A_VRG, 32'h0);
    chk(rd, 32'(`CSC_VREG_DEF));
    absent <= 1'b0;
    cmd.end_current_level_det <= 1'b0;
    cmd.bat_below_rch <= 1'b1;
    setc(7'h31);
    chk(32'(drv.mode), 32'(csc_pkg::M_HIZ));
    setc(7'h10);
    chk(32'(drv.mode), 32'(csc_pkg::M_CHG));
    cmd.chg_fault <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(32'({stat_oe, drv.mode}), 32'h6);
    run(1400);
    chk(32'(stat_oe), 32'h0);
    h0 = so_n;
    run(1400);
    chk(32'(so_n - h0), 32'h0);
    cmd.vbus_uvlo <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(32'(drv.mode), 32'(csc_pkg::M_HIZ));
    cmd.vbus_uvlo <= 1'b0;
    cmd.chg_fault <= 1'b0;
    run(1400);
    setc(7'h14);
    chk(32'(drv.mode), 32'(csc_pkg::M_BST));
    cmd.bst_fault <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(32'({stat_oe, drv.mode}), 32'h6);
    cmd.bst_fault <= 1'b0;
    setc(7'h1C);
    chk(32'(drv.mode), 32'(csc_pkg::M_HIZ));
    run(1400);
    setc(7'h30);
    cmd.tj_shut <= 1'b1;
    repeat (5) @(posedge mclk);
    h0 = hs_n;
    run(400);
    chk(32'(hs_n - h0), 32'h0);
    apb(1'b0, A_STA, 32'h0);
    chk(32'(rd[3]), 32'h1);
    cmd.tj_shut <= 1'b0;
    cmd.tj_cool <= 1'b1;
    apb(1'b0, A_STA, 32'h0);
    chk(32'(rd[3]), 32'h0);
    cmd.tj_cool <= 1'b0;
    cmd.vbus_below_bat <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(drv.blk_on), 32'h0);
    cmd.vbus_below_bat <= 1'b0;
    setc(7'h31);
    apb(1'b1, A_VRG, 32'h2F);
    apb(1'b1, A_CTL, 32'h33);
    apb(1'b0, A_CTL, 32'h0);
    chk(32'(rd[1]), 32'h0);
    apb(1'b0, A_VRG, 32'h0);
    chk(rd, 32'(`CSC_VREG_DEF));
    setc(7'h30);
    apb(1'b1, A_VRG, 32'h2F);
    repeat (1200) @(posedge mclk);
    apb(1'b0, A_STA, 32'h0);
    chk({rd[1], 25'h0000000, drv.vreg}, 32'(`CSC_VREG_DEF));
    repeat (2100) @(posedge mclk);
    apb(1'b0, A_STA, 32'h0);
    chk(32'({rd[2], stat_oe}), 32'h3);
    repeat (1400) @(posedge mclk);
    chk(32'({stat_oe, drv.hs_on}), 32'h0);
    print_verdict;
  end
endmodule
